// ### pkg/dmx_pkg.sv
package dmx_pkg;
  localparam int NUM_CH = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
  // Operand size codes of the channel set-up ports.
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;
  // Byte counts of each operand size.
  localparam logic [4:0] BYTES_BYTE = 5'h01;
  localparam logic [4:0] BYTES_WORD = 5'h02;
  localparam logic [4:0] BYTES_LONG = 5'h04;
  localparam logic [4:0] BYTES_LINE = 5'h10;
  // Bus cycle kind and modifier encodings.
  localparam logic [1:0] KIND_NORMAL = 2'h0;
  localparam logic [1:0] KIND_DMA = 2'h1;
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_CH0 = 2'h1;
  localparam logic [1:0] ACK_CH1 = 2'h2;
  // Reset values.
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [23:0] CNT_RST = 24'h00_0000;
  localparam logic [1:0] SYNC_RST = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD = 3'h1,
    ST_UNLD = 3'h3,
    ST_LOAD = 3'h2,
    ST_WR = 3'h6
  } dmx_state_t;
endpackage : dmx_pkg

// ### pkg/dmx_mem_if.sv
`timescale 1ns/1ps
interface dmx_mem_if #(
  parameter int W = 8,
  parameter int D = 16
);
  logic wr_en;
  logic [$clog2(D)-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [$clog2(D)-1:0] rd_addr;
  logic [W-1:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : dmx_mem_if

// ### hw/dmx_buf_mem.sv
`timescale 1ns/1ps
module dmx_buf_mem #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock.
  input wire logic i_core_clk,
  // Storage port.
  dmx_mem_if.mem mp
);
  logic [W-1:0] store [D];

  always_ff @(posedge i_core_clk) begin
    if (mp.wr_en) begin
      store[mp.wr_addr] <= mp.wr_data;
    end
  end

  // Write-first read so a word written this cycle is seen at once.
  always_ff @(posedge i_core_clk) begin
    if (mp.wr_en && (mp.wr_addr == mp.rd_addr)) begin
      mp.rd_data <= mp.wr_data;
    end else begin
      mp.rd_data <= store[mp.rd_addr];
    end
  end
endmodule : dmx_buf_mem

// ### hw/dmx_fifo.sv
`timescale 1ns/1ps
module dmx_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Fill side.
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side.
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  // Storage.
  dmx_mem_if.ctrl mp
);
  localparam int AW = $clog2(D);
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW+1)'(D));
  assign o_out_valid = (count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mp.rd_data;
  assign mp.wr_en = push;
  assign mp.wr_addr = wr_ptr;
  assign mp.wr_data = i_in_data;
  assign mp.rd_addr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + push - pop);
    end
  end

  fifo_bound_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (count == (AW+1)'(D)) |=> (count == (AW+1)'(D)) || $past(pop)) // [RULE15]
    else $error("buffer lost a byte while full");
  fifo_full_c: cover property (@(posedge i_core_clk) disable iff (i_srst)
    !o_in_ready);
endmodule : dmx_fifo

// ### hw/dmx_engine.sv
`timescale 1ns/1ps
// Contract
// RULE1 - Four channels, own pointers, count, control, status.
// RULE2 - Only channels 0 and 1 use request pins.
// RULE3 - Channels 2, 3 requested by serial ports.
// RULE4 - System holds unused request pins high.
// RULE5 - Peripheral asserts its request to move operand.
// RULE6 - Asserted request starts access on that channel.
// RULE7 - Each request pin selectable as port bit.
// RULE8 - Transfer kind output is 01 during DMA.
// RULE9 - Modifier meaningful only for internal channel cycles.
// RULE10 - Upper modifier: 00 none, 01 ch0, 10 ch1.
// RULE11 - Control bit: acknowledge every or last transfer.
// RULE12 - Lowest modifier bit marks single-address access.
// RULE13 - Single-address only to off-chip targets.
// RULE14 - Arbitration only at transfer boundaries.
// RULE15 - Blocks up to 128 bits via sixteen-byte buffer.
// RULE16 - Independent sizes with automatic access alignment.
// RULE17 - Continuous and cycle-steal request servicing.
// RULE18 - Transfer may complete in two clocks.
// RULE19 - Start bit raises an internal request.
// RULE20 - Request pins synchronised before use.
module dmx_engine #(
  parameter int ADDR_W = 32,
  parameter int CNT_W = 24,
  parameter int BUF_DEPTH = dmx_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Request sources.
  input wire logic [1:0] i_ext_transfer_request_n,
  input wire logic i_serial_port_a_irq,
  input wire logic i_serial_port_b_irq,
  input wire logic [1:0] i_pin_function_select,
  // Channel set-up.
  input wire logic [3:0] i_load,
  input wire logic [3:0][ADDR_W-1:0] i_source_pointer,
  input wire logic [3:0][ADDR_W-1:0] i_destination_pointer,
  input wire logic [3:0][CNT_W-1:0] i_byte_counter,
  input wire logic [3:0] i_start,
  input wire logic [3:0] i_request_enable,
  input wire logic [3:0] i_cycle_steal,
  input wire logic [3:0] i_ack_on_every_transfer,
  input wire logic [3:0] i_single_address_select,
  input wire logic [3:0] i_onchip_target,
  input wire logic [3:0] i_src_inc,
  input wire logic [3:0] i_dst_inc,
  input wire logic [3:0][1:0] i_src_size,
  input wire logic [3:0][1:0] i_dst_size,
  // Bus master side.
  input wire logic i_ext_master_active,
  input wire logic i_bus_ack,
  input wire logic [31:0] i_bus_rdata,
  output logic o_bus_rd,
  output logic o_bus_wr,
  output logic [ADDR_W-1:0] o_bus_addr,
  output logic [1:0] o_bus_size,
  output logic [31:0] o_bus_wdata,
  output logic [1:0] o_bus_cycle_kind,
  output logic [2:0] o_bus_cycle_modifier,
  // Status.
  output logic [1:0] o_parallel_port_bit,
  output logic [3:0] o_busy,
  output logic [3:0] o_done
);
  localparam int NCH = dmx_pkg::NUM_CH;
  localparam int FW = dmx_pkg::FIFO_WIDTH;

  function automatic logic [4:0] size_bytes(input logic [1:0] sz);
    case (sz)
      dmx_pkg::SZ_BYTE: size_bytes = dmx_pkg::BYTES_BYTE;
      dmx_pkg::SZ_WORD: size_bytes = dmx_pkg::BYTES_WORD;
      dmx_pkg::SZ_LINE: size_bytes = dmx_pkg::BYTES_LINE;
      default: size_bytes = dmx_pkg::BYTES_LONG;
    endcase
  endfunction : size_bytes

  // A misaligned address or a short remainder falls back to bytes.
  function automatic logic [4:0] beat_bytes(input logic [1:0] sz,
      input logic [1:0] a, input logic [4:0] left);
    logic [4:0] b;
    b = size_bytes(sz);
    if (b > dmx_pkg::BYTES_LONG) begin
      b = dmx_pkg::BYTES_LONG;
    end
    if ((b == dmx_pkg::BYTES_WORD && a[0]) ||
        (b == dmx_pkg::BYTES_LONG && a != 2'h0) || b > left) begin
      b = dmx_pkg::BYTES_BYTE; // [RULE16]
    end
    return b;
  endfunction : beat_bytes

  function automatic logic [1:0] size_code(input logic [4:0] b);
    case (b)
      dmx_pkg::BYTES_BYTE: size_code = dmx_pkg::SZ_BYTE;
      dmx_pkg::BYTES_WORD: size_code = dmx_pkg::SZ_WORD;
      default: size_code = dmx_pkg::SZ_LONG;
    endcase
  endfunction : size_code

  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [NCH-1:0] req_line;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] next_pend;
  logic [NCH-1:0] elig;
  logic [NCH-1:0][ADDR_W-1:0] src_ptr;
  logic [NCH-1:0][ADDR_W-1:0] dst_ptr;
  logic [NCH-1:0][CNT_W-1:0] cnt;
  dmx_pkg::dmx_state_t state;
  dmx_pkg::dmx_state_t next_state;
  logic [1:0] cur_ch;
  logic [1:0] next_ch;
  logic [ADDR_W-1:0] cur_src;
  logic [ADDR_W-1:0] next_src;
  logic [ADDR_W-1:0] cur_dst;
  logic [ADDR_W-1:0] next_dst;
  logic [4:0] blk_total;
  logic [4:0] next_blk_total;
  logic [4:0] blk_rd;
  logic [4:0] next_blk_rd;
  logic [4:0] blk_wr;
  logic [4:0] next_blk_wr;
  logic [4:0] beat;
  logic [4:0] next_beat;
  logic [4:0] bcnt;
  logic [4:0] next_bcnt;
  logic [31:0] rd_word;
  logic [31:0] next_rd_word;
  logic [31:0] wr_word;
  logic [31:0] next_wr_word;
  logic single;
  logic next_single;
  logic finish;
  logic cnt_last;
  logic any_elig;
  logic [1:0] pick;
  logic push_ready;
  logic pop_valid;
  logic [FW-1:0] pop_data;
  logic [FW-1:0] push_data;

  // Pins pass two flops; the second stage alone feeds logic.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sync1 <= dmx_pkg::SYNC_RST;
      sync2 <= dmx_pkg::SYNC_RST;
    end else begin
      sync1 <= i_ext_transfer_request_n; // [RULE20]
      sync2 <= sync1; // [RULE20]
    end
  end

  // Request pins low mean a request; idle pins are held high outside.
  assign req_line[0] = i_pin_function_select[0] && !sync2[0]; // [RULE2] [RULE4] [RULE7]
  assign req_line[1] = i_pin_function_select[1] && !sync2[1]; // [RULE2] [RULE4] [RULE7]
  assign req_line[2] = i_serial_port_a_irq; // [RULE3]
  assign req_line[3] = i_serial_port_b_irq; // [RULE3]

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_parallel_port_bit <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        o_parallel_port_bit[i] <= !i_pin_function_select[i] && sync2[i]; // [RULE7]
      end
    end
  end

  assign cnt_last = (cnt[cur_ch] <= CNT_W'(blk_total));
  assign finish = i_bus_ack && ((state == dmx_pkg::ST_RD && single) ||
    (state == dmx_pkg::ST_WR && blk_wr == beat));

  // A new request wins over the clear of the same cycle.
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_pend
      logic set;
      logic clr;
      assign set = i_start[c] || (req_line[c] && i_request_enable[c]); // [RULE5] [RULE6] [RULE19]
      assign clr = (cnt[c] == '0) || (finish && cur_ch == 2'(c) &&
        (i_cycle_steal[c] || cnt_last)); // [RULE17]
      assign next_pend[c] = set || (pend[c] && !clr);
      assign elig[c] = pend[c] && (cnt[c] != '0);
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pend <= '0;
      o_busy <= '0;
      o_done <= '0;
    end else begin
      pend <= next_pend;
      o_busy <= next_pend;
      for (int c = 0; c < NCH; c++) begin
        o_done[c] <= finish && cur_ch == 2'(c) && cnt_last;
      end
    end
  end

  // Per-channel pointers and counts, written back at transfer end.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      for (int c = 0; c < NCH; c++) begin
        src_ptr[c] <= ADDR_W'(dmx_pkg::ADDR_RST);
        dst_ptr[c] <= ADDR_W'(dmx_pkg::ADDR_RST);
        cnt[c] <= CNT_W'(dmx_pkg::CNT_RST);
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (i_load[c]) begin
          src_ptr[c] <= i_source_pointer[c]; // [RULE1]
          dst_ptr[c] <= i_destination_pointer[c]; // [RULE1]
          cnt[c] <= i_byte_counter[c]; // [RULE1]
        end else if (finish && cur_ch == 2'(c)) begin
          src_ptr[c] <= next_src;
          dst_ptr[c] <= next_dst;
          cnt[c] <= cnt_last ? '0 : CNT_W'(cnt[c] - blk_total);
        end
      end
    end
  end

  // The lowest eligible channel wins, sampled only while idle.
  always_comb begin
    pick = 2'h0;
    any_elig = 1'b0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (elig[c]) begin
        pick = 2'(c);
        any_elig = 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    next_ch = cur_ch;
    next_src = cur_src;
    next_dst = cur_dst;
    next_blk_total = blk_total;
    next_blk_rd = blk_rd;
    next_blk_wr = blk_wr;
    next_beat = beat;
    next_bcnt = bcnt;
    next_rd_word = rd_word;
    next_wr_word = wr_word;
    next_single = single;
    case (state)
      dmx_pkg::ST_IDLE: begin
        if (any_elig) begin
          next_ch = pick; // [RULE14]
          next_src = src_ptr[pick];
          next_dst = dst_ptr[pick];
          next_blk_total = size_bytes(i_src_size[pick]);
          if (size_bytes(i_dst_size[pick]) > next_blk_total) begin
            next_blk_total = size_bytes(i_dst_size[pick]); // [RULE16]
          end
          next_blk_rd = next_blk_total;
          next_blk_wr = next_blk_total;
          next_single = i_single_address_select[pick] &&
            !i_onchip_target[pick]; // [RULE13]
          next_beat = beat_bytes(i_src_size[pick], next_src[1:0],
            next_blk_total);
          next_state = dmx_pkg::ST_RD;
        end
      end
      dmx_pkg::ST_RD: begin
        if (i_bus_ack && single) begin
          // Request cycle plus acknowledge cycle ends the transfer.
          if (i_src_inc[cur_ch]) begin
            next_src = cur_src + ADDR_W'(beat); // [RULE18]
          end
          next_state = dmx_pkg::ST_IDLE;
        end else if (i_bus_ack) begin
          next_rd_word = i_bus_rdata;
          next_bcnt = 5'h00;
          next_state = dmx_pkg::ST_UNLD;
        end
      end
      dmx_pkg::ST_UNLD: begin
        if (push_ready) begin
          next_bcnt = 5'(bcnt + 1'b1);
          if (next_bcnt == beat) begin
            next_blk_rd = 5'(blk_rd - beat);
            if (i_src_inc[cur_ch]) begin
              next_src = cur_src + ADDR_W'(beat);
            end
            next_bcnt = 5'h00;
            if (next_blk_rd == 5'h00) begin
              next_wr_word = 32'h0000_0000;
              next_beat = beat_bytes(i_dst_size[cur_ch], cur_dst[1:0],
                blk_wr);
              next_state = dmx_pkg::ST_LOAD;
            end else begin
              next_beat = beat_bytes(i_src_size[cur_ch], next_src[1:0],
                next_blk_rd);
              next_state = dmx_pkg::ST_RD;
            end
          end
        end
      end
      dmx_pkg::ST_LOAD: begin
        if (pop_valid) begin
          next_wr_word = wr_word | (32'(pop_data) << {bcnt[1:0], 3'h0});
          next_bcnt = 5'(bcnt + 1'b1);
          if (next_bcnt == beat) begin
            next_state = dmx_pkg::ST_WR;
          end
        end
      end
      dmx_pkg::ST_WR: begin
        if (i_bus_ack) begin
          next_blk_wr = 5'(blk_wr - beat);
          if (i_dst_inc[cur_ch]) begin
            next_dst = cur_dst + ADDR_W'(beat);
          end
          next_bcnt = 5'h00;
          next_wr_word = 32'h0000_0000;
          if (next_blk_wr == 5'h00) begin
            next_state = dmx_pkg::ST_IDLE;
          end else begin
            next_beat = beat_bytes(i_dst_size[cur_ch], next_dst[1:0],
              next_blk_wr);
            next_state = dmx_pkg::ST_LOAD;
          end
        end
      end
      default: begin
        next_state = dmx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state <= dmx_pkg::ST_IDLE;
      cur_ch <= 2'h0;
      cur_src <= ADDR_W'(dmx_pkg::ADDR_RST);
      cur_dst <= ADDR_W'(dmx_pkg::ADDR_RST);
      blk_total <= 5'h00;
      blk_rd <= 5'h00;
      blk_wr <= 5'h00;
      beat <= 5'h00;
      bcnt <= 5'h00;
      rd_word <= 32'h0000_0000;
      wr_word <= 32'h0000_0000;
      single <= 1'b0;
    end else begin
      state <= next_state;
      cur_ch <= next_ch;
      cur_src <= next_src;
      cur_dst <= next_dst;
      blk_total <= next_blk_total;
      blk_rd <= next_blk_rd;
      blk_wr <= next_blk_wr;
      beat <= next_beat;
      bcnt <= next_bcnt;
      rd_word <= next_rd_word;
      wr_word <= next_wr_word;
      single <= next_single;
    end
  end

  // Bus outputs are registered copies of the next cycle's access.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_bus_rd <= 1'b0;
      o_bus_wr <= 1'b0;
      o_bus_addr <= ADDR_W'(dmx_pkg::ADDR_RST);
      o_bus_size <= dmx_pkg::SZ_LONG;
      o_bus_wdata <= 32'h0000_0000;
      o_bus_cycle_kind <= dmx_pkg::KIND_NORMAL;
      o_bus_cycle_modifier <= 3'h0;
    end else begin
      o_bus_rd <= (next_state == dmx_pkg::ST_RD);
      o_bus_wr <= (next_state == dmx_pkg::ST_WR);
      o_bus_addr <= (next_state == dmx_pkg::ST_WR) ? next_dst : next_src;
      o_bus_size <= size_code(next_beat);
      o_bus_wdata <= next_wr_word;
      if (next_state == dmx_pkg::ST_RD || next_state == dmx_pkg::ST_WR) begin
        o_bus_cycle_kind <= dmx_pkg::KIND_DMA; // [RULE8]
        o_bus_cycle_modifier[0] <= next_single; // [RULE12]
        if (i_ack_on_every_transfer[next_ch] ||
            cnt[next_ch] <= CNT_W'(next_blk_total)) begin // [RULE11]
          case (next_ch)
            2'h0: o_bus_cycle_modifier[2:1] <= dmx_pkg::ACK_CH0; // [RULE10]
            2'h1: o_bus_cycle_modifier[2:1] <= dmx_pkg::ACK_CH1; // [RULE10]
            default: o_bus_cycle_modifier[2:1] <= dmx_pkg::ACK_NONE;
          endcase
        end else begin
          o_bus_cycle_modifier[2:1] <= dmx_pkg::ACK_NONE;
        end
      end else begin
        o_bus_cycle_kind <= i_ext_master_active ? dmx_pkg::KIND_DMA :
          dmx_pkg::KIND_NORMAL; // [RULE8]
        o_bus_cycle_modifier <= 3'h0; // [RULE9]
      end
    end
  end

  dmx_mem_if #(.W(FW), .D(BUF_DEPTH)) buf_if ();

  assign push_data = rd_word[{bcnt[1:0], 3'h0} +: 8];

  dmx_fifo #(.W(FW), .D(BUF_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_in_valid(state == dmx_pkg::ST_UNLD), // [RULE15]
    .o_in_ready(push_ready),
    .i_in_data(push_data),
    .o_out_valid(pop_valid),
    .i_out_ready(state == dmx_pkg::ST_LOAD),
    .o_out_data(pop_data),
    .mp(buf_if.ctrl)
  );

  dmx_buf_mem #(.W(FW), .D(BUF_DEPTH)) u_mem (
    .i_core_clk(i_core_clk),
    .mp(buf_if.mem)
  );

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  kind_dma_a: assert property ((o_bus_rd || o_bus_wr) |->
    o_bus_cycle_kind == dmx_pkg::KIND_DMA) // [RULE8]
    else $error("bus cycle kind not 01 during transfer");
  mod_idle_a: assert property (!(o_bus_rd || o_bus_wr) |->
    o_bus_cycle_modifier == 3'h0) // [RULE9]
    else $error("modifier driven outside channel cycle");
  mod_rsvd_a: assert property (o_bus_cycle_modifier[2:1] != 2'h3) // [RULE10]
    else $error("reserved modifier code driven");
  ack_every_a: assert property (o_bus_rd && cur_ch == 2'h1 &&
    i_ack_on_every_transfer[1] |-> o_bus_cycle_modifier[2:1] ==
    dmx_pkg::ACK_CH1) // [RULE11]
    else $error("channel 1 acknowledge code missing");
  single_mod_a: assert property (o_bus_rd && single |->
    o_bus_cycle_modifier[0] && !i_onchip_target[cur_ch]) // [RULE12] [RULE13]
    else $error("single-address marking wrong");
  arb_hold_a: assert property (state != dmx_pkg::ST_IDLE &&
    $past(state) != dmx_pkg::ST_IDLE |-> $stable(cur_ch)) // [RULE14]
    else $error("channel switched mid transfer");
  sync_lat_a: assert property (i_pin_function_select[0] &&
    $past(i_pin_function_select[0]) && req_line[0] |->
    !$past(i_ext_transfer_request_n[0], 2)) // [RULE20]
    else $error("request used before two flops");
  start_pend_a: assert property (i_start != 4'h0 |=>
    (pend & $past(i_start)) == $past(i_start)) // [RULE19]
    else $error("start did not raise request");
  two_clk_a: assert property ($rose(o_bus_rd) && single ##1 i_bus_ack |=>
    !o_bus_rd && state == dmx_pkg::ST_IDLE) // [RULE18]
    else $error("single transfer did not end in two clocks");

  single_c: cover property (o_bus_rd && single ##1 i_bus_ack);
  line_c: cover property (state == dmx_pkg::ST_LOAD && blk_total ==
    dmx_pkg::BYTES_LINE);
  steal_c: cover property (o_done[0] && i_cycle_steal[0]);
endmodule : dmx_engine

// ### sim/dmx_bus_partner.sv
`timescale 1ns/1ps
module dmx_bus_partner (
  // Clock.
  input wire logic i_core_clk,
  // Bus cycle from the engine, and the wait-state select.
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [31:0] i_addr,
  input wire logic i_slow,
  // Answer.
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [2:0] wait_cnt = 3'h0;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
  end
  // Outside an acknowledged read or write the data lines invert every cycle.
  always @(posedge i_core_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if ((i_rd || i_wr) && !o_ack) begin
      wait_cnt <= wait_cnt + 3'h1;
      if (!i_slow || wait_cnt == 3'h3) begin
        o_ack <= 1'b1;
        o_rdata <= i_addr ^ 32'hA5A5_5A5A;
        wait_cnt <= 3'h0;
      end
    end
  end
endmodule : dmx_bus_partner

// ### sim/dmx_engine_tb.sv
`timescale 1ns/1ps
module dmx_engine_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] req_n = 2'h3;
  logic [1:0] pin_sel = 2'h3;
  logic irq_a = 1'b0;
  logic irq_b = 1'b0;
  logic ext_mst = 1'b0;
  logic slow = 1'b0;
  logic [3:0] load = 4'h0, start = 4'h0, req_en = 4'h0, steal = 4'h0;
  logic [3:0] every = 4'h0, sa = 4'h0, onchip = 4'h0;
  logic [3:0] sinc = 4'hF, dinc = 4'h0;
  logic [3:0][31:0] sp = '0, dp = '0;
  logic [3:0][23:0] bc = '0;
  logic [3:0][1:0] ssz = '0, dsz = '0;
  logic rd, wr, ack;
  logic [31:0] addr, wdata, rdata;
  logic [1:0] bsz, kind, ppb;
  logic [2:0] bmod;
  logic [3:0] busy, done;
  logic [2:0] mods[$];
  logic [7:0] q[$];
  logic [31:0] exp_a;
  logic [1:0] ec;
  logic h;
  int per, rb, wb, nb, cur;
  int bad_count = 0;
  int check_count = 0;
  int k;
  int n;

  always #2 core_clk = ~core_clk;

  dmx_engine dmx_engine_i (
    .i_core_clk(core_clk), .i_srst(srst),
    .i_ext_transfer_request_n(req_n), .i_serial_port_a_irq(irq_a),
    .i_serial_port_b_irq(irq_b), .i_pin_function_select(pin_sel),
    .i_load(load), .i_source_pointer(sp), .i_destination_pointer(dp),
    .i_byte_counter(bc), .i_start(start), .i_request_enable(req_en),
    .i_cycle_steal(steal), .i_ack_on_every_transfer(every),
    .i_single_address_select(sa), .i_onchip_target(onchip),
    .i_src_inc(sinc), .i_dst_inc(dinc), .i_src_size(ssz),
    .i_dst_size(dsz), .i_ext_master_active(ext_mst), .i_bus_ack(ack),
    .i_bus_rdata(rdata), .o_bus_rd(rd), .o_bus_wr(wr), .o_bus_addr(addr),
    .o_bus_size(bsz), .o_bus_wdata(wdata), .o_bus_cycle_kind(kind),
    .o_bus_cycle_modifier(bmod), .o_parallel_port_bit(ppb),
    .o_busy(busy), .o_done(done));
  dmx_bus_partner dmx_bus_partner_i (.i_core_clk(core_clk), .i_rd(rd),
    .i_wr(wr), .i_addr(addr), .i_slow(slow), .o_ack(ack), .o_rdata(rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic int szb(logic [1:0] c);
    return c == dmx_pkg::SZ_BYTE ? 1 : c == dmx_pkg::SZ_WORD ? 2 :
      c == dmx_pkg::SZ_LINE ? 16 : 4;
  endfunction : szb

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  function automatic logic [2:0] exp_mod(int ch, logic ev, logic lst,
                                         logic s);
    logic [1:0] code;
    code = ch == 0 ? dmx_pkg::ACK_CH0 : dmx_pkg::ACK_NONE;
    if (ch == 1) begin
      code = dmx_pkg::ACK_CH1;
    end
    return {(ev || lst) ? code : dmx_pkg::ACK_NONE, s};
  endfunction : exp_mod

  // Every acknowledged beat is logged; bytes of each non-single-address read queue up in order
  // and each write must drain them through the staging buffer.
  always @(posedge core_clk) begin
    if ((rd || wr) && ack) begin
      mods.push_back(bmod);
      nb = rd ? rb : wb;
      ec = nb == 1 ? dmx_pkg::SZ_BYTE : nb == 2 ? dmx_pkg::SZ_WORD :
        dmx_pkg::SZ_LONG;
      check(kind, dmx_pkg::KIND_DMA);
      check(addr, rd ? exp_a : dp[cur]);
      check(bsz, ec);
      for (int j = 0; j < nb; j++) begin
        if (rd && per > 1) begin
          q.push_back(rdata[8*j +: 8]);
        end else if (wr) begin
          check(wdata[8*j +: 8], q.pop_front());
        end
      end
      if (rd) begin
        exp_a += 32'(rb);
      end
    end
  end

  // Pointers are long-aligned so the beat count follows from the sizes.
  task automatic run(int ch, logic ev, logic s, logic oc, logic st,
                     logic hw, int cnt, logic [1:0] ss, logic [1:0] ds);
    int w, b;
    b = szb(ss) > szb(ds) ? szb(ss) : szb(ds);
    rb = szb(ss) > 4 ? 4 : szb(ss);
    wb = szb(ds) > 4 ? 4 : szb(ds);
    per = (s && !oc) ? 1 : b / rb + b / wb;
    cur = ch;
    exp_a = $urandom & 32'hFFFF_FFFC;
    mods.delete();
    q.delete();
    load[ch] <= 1'b1;
    sp[ch] <= exp_a;
    dp[ch] <= $urandom & 32'hFFFF_FFFC;
    bc[ch] <= 24'(cnt * b);
    ssz[ch] <= ss;
    dsz[ch] <= ds;
    every[ch] <= ev;
    sa[ch] <= s;
    onchip[ch] <= oc;
    steal[ch] <= st;
    req_en[ch] <= hw;
    @(posedge core_clk);
    load <= 4'h0;
    if (!hw) begin
      start[ch] <= 1'b1;
    end else if (ch < 2) begin
      req_n[ch] <= 1'b0;
    end else if (ch == 2) begin
      irq_a <= 1'b1;
    end else begin
      irq_b <= 1'b1;
    end
    @(posedge core_clk);
    start <= 4'h0;
    w = 0;
    do begin
      @(negedge core_clk);
      w++;
    end while (done[ch] !== 1'b1 && w < 2000);
    check(w < 2000, 1);
    @(posedge core_clk);
    req_n <= 2'h3;
    irq_a <= 1'b0;
    irq_b <= 1'b0;
    req_en <= 4'h0;
    repeat (4) @(posedge core_clk);
    check(mods.size(), cnt * per);
    check(q.size(), 0);
    for (w = 0; w < mods.size(); w++) begin
      check(mods[w], exp_mod(ch, ev, w >= cnt * per - per, per == 1));
    end
  endtask : run

  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(78));
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    check({kind, bmod, busy, done, rd, wr}, 0);
    @(posedge core_clk);
    ext_mst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check({kind, bmod}, {dmx_pkg::KIND_DMA, 3'h0});
    ext_mst <= 1'b0;
    pin_sel <= 2'h0;
    req_n <= 2'h1;
    req_en <= 4'h3;
    repeat (4) @(posedge core_clk);
    check({ppb, busy}, {2'h1, 4'h0});
    pin_sel <= 2'h3;
    req_n <= 2'h3;
    req_en <= 4'h0;
    repeat (4) @(posedge core_clk);
    run(0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1, 2'h1, 2'h1);
    run(1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1, 2'h2, 2'h0);
    run(2, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2, 2'h1, 2'h3);
    run(3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3, 2'h3, 2'h1);
    run(0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 3, 2'h1, 2'h1);
    run(1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2, 2'h0, 2'h2);
    // A software start is one request, so cycle steal goes with hardware requests (pins or serial ports).
    repeat (8) begin
      slow <= 1'($urandom);
      n = $urandom % 4;
      k = $urandom % 2;
      h = 1'($urandom);
      run(n, ($urandom % 2) || k == 0, 1'(k), 1'b0, h & 1'($urandom), h,
          1 + $urandom % 3, 2'($urandom), 2'($urandom));
    end
    end_of_test();
  end
endmodule : dmx_engine_tb
